// *** include/ssw_pkg.sv ***
package ssw_pkg;
  // Overview of operation
  // - a floating strobe input switches the watchdog timer fully off
  // - a strobe held steady past the timeout pulls reset and expiry low
  // - every strobe transition restarts the timeout; host must toggle in time
  // - expiry flag returns high on next strobe transition or on supply low
  // - reset is asserted whenever the supply comparator reports supply low
  // - after supply recovers reset stays asserted at least 140 ms
  // - active-high reset is always the inverse of active-low reset
  // - supply-low output follows the supply comparator three clock cycles later (two sync stages plus the output register)
  // - switchover comparator decision, with its hysteresis, selects backup mode
  // - backup mode forces every supervisor output except IRQ_OUT to its fixed state
  // - backup mode ignores strobe, memory select, fail sense and timebase
  // - memory select follows its input when supply good and not in backup, else forced high
  // - right after reset the long watchdog timeout applies
  // - unserviced watchdog issues a 140 ms reset at each timeout
  // - fail warning is high above the fail reference, low below it

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int EXT_DIV = 64;
  localparam int HOLD_MS = 140;
  localparam int WD_LONG_MS = 1600;
  localparam int WD_SHORT_MS = 100;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] HOLD_TICKS = CNT_W'(HOLD_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] WD_LONG_TICKS = CNT_W'(WD_LONG_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] WD_SHORT_TICKS = CNT_W'(WD_SHORT_MS * 1000 / TICK_US);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AXI_AW = 5;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_IRQ_STAT = 2'h2;
  localparam logic [1:0] REG_IRQ_MASK = 2'h3;
  localparam int CTRL_WDEN_BIT = 0;
  localparam logic CTRL_WDEN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status word, bit 0 is supply_ok
  typedef struct packed {
    logic long_tmo;
    logic floating;
    logic expired;
    logic in_reset;
    logic fail_ok;
    logic backup;
    logic supply_ok;
  } ssw_status_s;

  // interrupt events, bit 0 is expiry
  typedef struct packed {
    logic backup;
    logic fail;
    logic low;
    logic expiry;
  } ssw_irq_s;

  typedef enum logic [1:0] {
    ST_LOW = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b11
  } ssw_state_e;
endpackage

// *** include/ssw_tick_if.sv ***
`timescale 1ns/10ps
interface ssw_tick_if;
  logic sel;
  logic ext_lvl;
  logic tick;
  // timebase generator side
  modport gen (input sel, input ext_lvl, output tick);
  // consumer side
  modport core (output sel, output ext_lvl, input tick);
endinterface

// *** logic/ssw_supervisor.sv ***
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [CNT_W-1:0] HOLD_T = HOLD_TICKS,
  parameter logic [CNT_W-1:0] WD_LONG_T = WD_LONG_TICKS,
  parameter logic [CNT_W-1:0] WD_SHORT_T = WD_SHORT_TICKS
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // comparator decisions
  input wire logic SUPPLY_COMPARATOR_IN,
  input wire logic SWITCHOVER_COMPARATOR_IN,
  input wire logic FAIL_COMPARATOR_IN,
  // host side inputs
  input wire logic WATCHDOG_STROBE_HI_IN,
  input wire logic WATCHDOG_STROBE_LO_IN,
  input wire logic MEM_SELECT_N_IN,
  // timebase
  input wire logic TIMEBASE_IN,
  input wire logic TIMEBASE_SELECT_IN,
  // supervisor outputs
  output logic RESET_N_OUT,
  output logic RESET_OUT,
  output logic SUPPLY_LOW_N_OUT,
  output logic FAIL_WARNING_N_OUT,
  output logic WATCHDOG_EXPIRED_N_OUT,
  output logic MEM_SELECT_N_OUT,
  output logic BACKUP_ACTIVE_OUT,
  output logic IRQ_OUT,
  // axi4-lite write
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  // axi4-lite read
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR_IN,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  // ----------------------------------------------------------------
  // input capture and timebase
  // ----------------------------------------------------------------
  logic [7:0] pins_s;
  logic sup_s, bak_s, fail_s, hi_s, lo_s, mem_s, tbin_s, tbsel_s;
  ssw_tick_if tbi ();

  ssw_sync #(.W(8)) u_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .d_in({TIMEBASE_SELECT_IN, TIMEBASE_IN, MEM_SELECT_N_IN, WATCHDOG_STROBE_LO_IN,
           WATCHDOG_STROBE_HI_IN, FAIL_COMPARATOR_IN, SWITCHOVER_COMPARATOR_IN,
           SUPPLY_COMPARATOR_IN}),
    .q_out(pins_s)
  );

  assign {tbsel_s, tbin_s, mem_s, lo_s, hi_s, fail_s, bak_s, sup_s} = pins_s;
  assign tbi.sel = tbsel_s;
  assign tbi.ext_lvl = tbin_s;

  ssw_timebase #(.DIV_CYC(TICK_CYCLES)) u_tb (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .tb(tbi.gen)
  );

  // ----------------------------------------------------------------
  // reset and watchdog sequencer
  // ----------------------------------------------------------------
  ssw_state_e st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic lvl_ff, nxt_lvl;
  logic long_ff, nxt_long;
  logic exp_ff, nxt_exp;
  logic ctrl_wden_ff;
  logic driven, floating, wd_edge, wd_on, tick, down;
  logic [CNT_W-1:0] limit;

  // strobe decode and qualifiers
  always_comb begin
    driven = hi_s ^ lo_s;
    floating = ~driven;
    wd_edge = driven && !bak_s && (hi_s != lvl_ff);
    tick = tbi.tick && !bak_s;
    wd_on = driven && ctrl_wden_ff;
    down = !sup_s || bak_s;
    limit = (long_ff || !tbsel_s || tbin_s) ? WD_LONG_T : WD_SHORT_T;
  end

  // next state of the sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_lvl = (driven && !bak_s) ? hi_s : lvl_ff;
    nxt_long = long_ff;
    nxt_exp = exp_ff;
    if (wd_edge || floating) begin
      nxt_exp = 1'b0;
    end
    if (down) begin
      nxt_st = ST_LOW;
      nxt_cnt = '0;
      nxt_long = 1'b1;
      nxt_exp = 1'b0;
    end else begin
      unique case (st_ff)
        ST_LOW: begin
          nxt_st = ST_HOLD;
          nxt_cnt = '0;
        end
        ST_HOLD: begin
          if (tick) begin
            if (cnt_ff == HOLD_T) begin
              nxt_st = ST_RUN;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (wd_edge) begin
            nxt_cnt = '0;
            nxt_long = 1'b0;
          end else if (!wd_on) begin
            nxt_cnt = '0;
          end else if (tick) begin
            if (cnt_ff == limit) begin
              nxt_st = ST_HOLD;
              nxt_cnt = '0;
              nxt_exp = 1'b1;
              nxt_long = 1'b1;
            end else begin
              nxt_cnt = cnt_ff + 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_ff <= ST_LOW;
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
      long_ff <= 1'b1;
      exp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
      long_ff <= nxt_long;
      exp_ff <= nxt_exp;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic rst_n_ff, nxt_rst_n;
  logic low_n_ff, nxt_low_n;
  logic fail_n_ff, nxt_fail_n;
  logic expn_ff, nxt_expn;
  logic mem_ff, nxt_mem;
  logic bako_ff, nxt_bako;

  // output values, backup overrides all
  always_comb begin
    nxt_rst_n = !bak_s && (nxt_st == ST_RUN);
    nxt_low_n = !bak_s && sup_s;
    nxt_fail_n = !bak_s && fail_s;
    nxt_expn = bak_s || !nxt_exp;
    nxt_mem = down || mem_s;
    nxt_bako = bak_s;
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_n_ff <= 1'b0;
      low_n_ff <= 1'b0;
      fail_n_ff <= 1'b0;
      expn_ff <= 1'b1;
      mem_ff <= 1'b1;
      bako_ff <= 1'b0;
    end else begin
      rst_n_ff <= nxt_rst_n;
      low_n_ff <= nxt_low_n;
      fail_n_ff <= nxt_fail_n;
      expn_ff <= nxt_expn;
      mem_ff <= nxt_mem;
      bako_ff <= nxt_bako;
    end
  end

  assign RESET_N_OUT = rst_n_ff;
  assign RESET_OUT = ~rst_n_ff;
  assign SUPPLY_LOW_N_OUT = low_n_ff;
  assign FAIL_WARNING_N_OUT = fail_n_ff;
  assign WATCHDOG_EXPIRED_N_OUT = expn_ff;
  assign MEM_SELECT_N_OUT = mem_ff;
  assign BACKUP_ACTIVE_OUT = bako_ff;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [AXI_AW-1:0] awa_ff, nxt_awa;
  logic [7:0] wd_ff, nxt_wd;
  logic wstb_ff, nxt_wstb;
  logic [31:0] rdata_ff, nxt_rdata;
  logic nxt_wden;
  ssw_irq_s irq_ff, nxt_irq, mask_ff, nxt_mask, ev;
  ssw_status_s sts;
  logic [2:0] wdec, rdec;
  logic do_wr;

  // mapped flag and word index
  function automatic logic [2:0] decode(input logic [AXI_AW-1:0] a);
    decode = {~a[4], a[3:2]};
  endfunction

  // events and status word
  always_comb begin
    ev.expiry = nxt_exp && !exp_ff;
    ev.low = !nxt_low_n && low_n_ff;
    ev.fail = !nxt_fail_n && fail_n_ff;
    ev.backup = bak_s && !bako_ff;
    sts = '{long_tmo: long_ff, floating: floating, expired: exp_ff,
            in_reset: !rst_n_ff, fail_ok: fail_s, backup: bak_s, supply_ok: sup_s};
  end

  // write and read channels
  always_comb begin
    wdec = decode(awa_ff);
    rdec = decode(S_AXI_ARADDR_IN);
    do_wr = aw_ff && w_ff && !bv_ff;
    nxt_aw = aw_ff || S_AXI_AWVALID_IN;
    nxt_awa = (!aw_ff && S_AXI_AWVALID_IN) ? S_AXI_AWADDR_IN : awa_ff;
    nxt_w = w_ff || S_AXI_WVALID_IN;
    nxt_wd = (!w_ff && S_AXI_WVALID_IN) ? S_AXI_WDATA_IN[7:0] : wd_ff;
    nxt_wstb = (!w_ff && S_AXI_WVALID_IN) ? S_AXI_WSTRB_IN[0] : wstb_ff;
    nxt_bv = bv_ff && !S_AXI_BREADY_IN;
    nxt_bresp = bresp_ff;
    nxt_wden = ctrl_wden_ff;
    nxt_mask = mask_ff;
    nxt_irq = irq_ff;
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_bresp = wdec[2] ? RESP_OKAY : RESP_SLVERR;
      if (wdec[2] && wstb_ff) begin
        if (wdec[1:0] == REG_CTRL) nxt_wden = wd_ff[CTRL_WDEN_BIT];
        if (wdec[1:0] == REG_IRQ_MASK) nxt_mask = ssw_irq_s'(wd_ff[3:0]);
        if (wdec[1:0] == REG_IRQ_STAT) nxt_irq = ssw_irq_s'(irq_ff & ~wd_ff[3:0]);
      end
    end
    // new events win over a clear
    nxt_irq = ssw_irq_s'(nxt_irq | ev);
    nxt_rv = rv_ff && !S_AXI_RREADY_IN;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (S_AXI_ARVALID_IN && !rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rresp = rdec[2] ? RESP_OKAY : RESP_SLVERR;
      unique case ({rdec[2], rdec[1:0]})
        {1'b1, REG_CTRL}: nxt_rdata = {31'h0, ctrl_wden_ff};
        {1'b1, REG_STATUS}: nxt_rdata = {25'h0, sts};
        {1'b1, REG_IRQ_STAT}: nxt_rdata = {28'h0, irq_ff};
        {1'b1, REG_IRQ_MASK}: nxt_rdata = {28'h0, mask_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      aw_ff <= 1'b0;
      awa_ff <= '0;
      w_ff <= 1'b0;
      wd_ff <= 8'h0;
      wstb_ff <= 1'b0;
      bv_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rv_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0;
      ctrl_wden_ff <= CTRL_WDEN_RST;
      irq_ff <= '0;
      mask_ff <= '0;
    end else begin
      aw_ff <= nxt_aw;
      awa_ff <= nxt_awa;
      w_ff <= nxt_w;
      wd_ff <= nxt_wd;
      wstb_ff <= nxt_wstb;
      bv_ff <= nxt_bv;
      bresp_ff <= nxt_bresp;
      rv_ff <= nxt_rv;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_wden_ff <= nxt_wden;
      irq_ff <= nxt_irq;
      mask_ff <= nxt_mask;
    end
  end

  assign S_AXI_AWREADY_OUT = !aw_ff;
  assign S_AXI_WREADY_OUT = !w_ff;
  assign S_AXI_BVALID_OUT = bv_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;
  assign S_AXI_ARREADY_OUT = !rv_ff;
  assign S_AXI_RVALID_OUT = rv_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;
  assign IRQ_OUT = |(irq_ff & mask_ff);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence run_expiry_s;
    st_ff == ST_RUN && !down && wd_on && !wd_edge && tick && cnt_ff == limit;
  endsequence
  sequence pulse_s;
    exp_ff && st_ff == ST_HOLD && long_ff;
  endsequence

  rst_inverse_a: assert property (RESET_OUT == !RESET_N_OUT)
    else $error("active-high reset not inverse of active-low reset");
  supply_reset_a: assert property (!sup_s |=> !RESET_N_OUT && !SUPPLY_LOW_N_OUT)
    else $error("reset not asserted with supply low");
  low_follow_a: assert property (sup_s && !bak_s |=> SUPPLY_LOW_N_OUT)
    else $error("supply-low output delayed");
  hold_min_a: assert property ($rose(RESET_N_OUT) |-> $past(cnt_ff, 2) == HOLD_T)
    else $error("reset released before hold count");
  backup_force_a: assert property (bak_s |=> !RESET_N_OUT && !FAIL_WARNING_N_OUT &&
    !SUPPLY_LOW_N_OUT && WATCHDOG_EXPIRED_N_OUT && MEM_SELECT_N_OUT && BACKUP_ACTIVE_OUT)
    else $error("backup output states wrong");
  backup_ignore_a: assert property (bak_s |=> $stable(lvl_ff) && cnt_ff == 0)
    else $error("input acted on in backup");
  float_off_a: assert property (floating && st_ff == ST_RUN && !down |=> cnt_ff == 0 && !exp_ff)
    else $error("floating strobe did not stop the timer");
  expiry_a: assert property (run_expiry_s |=> pulse_s ##1 !RESET_N_OUT)
    else $error("timeout did not raise reset and expiry");
  pulse_repeat_a: assert property (pulse_s and $rose(exp_ff) |-> ##1 !RESET_N_OUT[*2])
    else $error("watchdog reset pulse missing");
  restart_a: assert property (wd_edge && st_ff == ST_RUN && !down |=> cnt_ff == 0 && !exp_ff)
    else $error("strobe transition did not restart timer");
  expiry_clear_a: assert property (exp_ff && (wd_edge || down) |=> ##1 WATCHDOG_EXPIRED_N_OUT)
    else $error("expiry output not returned high");
  long_after_a: assert property (st_ff == ST_HOLD |-> long_ff)
    else $error("long timeout not armed after reset");
  mem_gate_a: assert property (!down |=> MEM_SELECT_N_OUT == $past(mem_s))
    else $error("memory select not following input");
  fail_follow_a: assert property (!bak_s |=> FAIL_WARNING_N_OUT == $past(fail_s))
    else $error("fail warning not following comparator");
endmodule

// *** logic/ssw_sync.sv ***
`timescale 1ns/10ps
module ssw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // two-stage chain, first stage feeds only the second
  always_comb begin
    nxt_meta = d_in;
    nxt_q = meta_ff;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q_out = q_ff;
endmodule

// *** logic/ssw_timebase.sv ***
`timescale 1ns/10ps
module ssw_timebase
  import ssw_pkg::*;
#(
  parameter int DIV_CYC = TICK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // tick exchange
  ssw_tick_if.gen tb
);
  localparam int DW = $clog2(DIV_CYC);
  localparam int EW = $clog2(EXT_DIV);
  logic [DW-1:0] div_ff;
  logic [DW-1:0] nxt_div;
  logic [EW-1:0] ext_ff;
  logic [EW-1:0] nxt_ext;
  logic lvl_ff;
  logic nxt_lvl;
  logic tick_ff;
  logic nxt_tick;
  logic rise;

  // internal divider or external clock divided by 64
  // selected tick source
  always_comb begin
    rise = tb.ext_lvl & ~lvl_ff;
    nxt_lvl = tb.ext_lvl;
    nxt_div = (div_ff == DW'(DIV_CYC - 1)) ? '0 : div_ff + 1'b1;
    nxt_ext = rise ? ext_ff + 1'b1 : ext_ff;
    nxt_tick = tb.sel ? (div_ff == DW'(DIV_CYC - 1)) : (rise && (&ext_ff));
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_ff <= '0;
      ext_ff <= '0;
      lvl_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ext_ff <= nxt_ext;
      lvl_ff <= nxt_lvl;
      tick_ff <= nxt_tick;
    end
  end

  assign tb.tick = tick_ff;
endmodule

// *** test/ssw_host_model.sv ***
`timescale 1ns/10ps
module ssw_host_model (
  // clock
  input wire logic clk_in,
  // mode 0 float, 1 toggle, 2 hold level; toggle spacing
  input wire logic [1:0] mode_in,
  input wire logic [7:0] gap_in,
  // decoded strobe lines
  output logic hi_out,
  output logic lo_out
);
  logic lvl_ff = 1'b0;
  logic [7:0] cnt_ff = 8'h00;

  // ---------------------------------------------
  // strobe service
  // ---------------------------------------------
  // host toggles in time
  always @(posedge clk_in) begin
    if (mode_in == 2'h1 && cnt_ff + 8'h01 < gap_in) begin
      cnt_ff <= cnt_ff + 8'h01;
    end else begin
      cnt_ff <= 8'h00;
    end
    if (mode_in == 2'h1 && cnt_ff + 8'h01 >= gap_in) begin
      lvl_ff <= ~lvl_ff;
    end
  end

  // floating shows both lines low
  assign hi_out = (mode_in != 2'h0) & lvl_ff;
  assign lo_out = (mode_in != 2'h0) & ~lvl_ff;
endmodule

// *** test/ssw_supervisor_bench.sv ***
`timescale 1ns/10ps
module ssw_supervisor_bench
  import ssw_pkg::*;
;
  localparam int TK = 4;
  localparam int HT = 3;
  localparam int WL = 12;
  localparam int WS = 6;
  logic clk, rstn, sup, swo, fail, msel, tbi, tbs;
  logic [1:0] mode;
  logic [7:0] gap;
  logic hi, lo, rst_n, rst, low_n, fw_n, exp_n, msel_o, bk, irq;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [4:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, resp;
  int fails = 0;
  int checked = 0;
  int n;

  // ---------------------------------------------
  // clock, design and host
  // ---------------------------------------------
  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ssw_supervisor #(.TICK_CYCLES(TK), .HOLD_T(CNT_W'(HT)), .WD_LONG_T(CNT_W'(WL)),
    .WD_SHORT_T(CNT_W'(WS))) dut (
    .CLK_IN(clk), .RSTN_IN(rstn), .SUPPLY_COMPARATOR_IN(sup),
    .SWITCHOVER_COMPARATOR_IN(swo), .FAIL_COMPARATOR_IN(fail),
    .WATCHDOG_STROBE_HI_IN(hi), .WATCHDOG_STROBE_LO_IN(lo), .MEM_SELECT_N_IN(msel),
    .TIMEBASE_IN(tbi), .TIMEBASE_SELECT_IN(tbs), .RESET_N_OUT(rst_n), .RESET_OUT(rst),
    .SUPPLY_LOW_N_OUT(low_n), .FAIL_WARNING_N_OUT(fw_n), .WATCHDOG_EXPIRED_N_OUT(exp_n),
    .MEM_SELECT_N_OUT(msel_o), .BACKUP_ACTIVE_OUT(bk), .IRQ_OUT(irq),
    .S_AXI_AWVALID_IN(aw_v), .S_AXI_AWREADY_OUT(aw_r), .S_AXI_AWADDR_IN(awa),
    .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(w_r), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_BVALID_OUT(b_v), .S_AXI_BREADY_IN(b_r),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_r),
    .S_AXI_ARADDR_IN(ara), .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(r_r),
    .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp));

  ssw_host_model host (.clk_in(clk), .mode_in(mode), .gap_in(gap), .hi_out(hi), .lo_out(lo));

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // write one word, ready lines stay high throughout
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    bit done;
    done = 1'b0;
    {aw_v, w_v} <= 2'h3;
    awa <= a;
    wd <= v;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (b_v) begin
        resp = bresp;
        done = 1'b1;
        break;
      end
    end
    // no answer counts as a mismatch
    if (!done) fails++;
  endtask

  // read one word into d
  task automatic rd(input logic [4:0] a);
    bit done;
    done = 1'b0;
    ar_v <= 1'b1;
    ara <= a;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'b0;
      if (r_v) begin
        d = rdat;
        resp = rresp;
        done = 1'b1;
        break;
      end
    end
    // no answer counts as a mismatch
    if (!done) fails++;
  endtask

  // cycles until reset output reaches a level
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (rst_n !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) fails++;
  endtask

  // cycles until expiry output reaches a level
  task automatic wait_exp(input logic lvl);
    n = 0;
    while (exp_n !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) fails++;
  endtask

  // cycles with reset or expiry active over a quiet span
  task automatic count_trips(input int span);
    n = 0;
    repeat (span) begin
      @(posedge clk);
      if (rst_n !== 1'b1 || exp_n !== 1'b1) n++;
    end
  endtask

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  // main test flow
  initial begin
    {rstn, sup, swo, fail, msel, tbi, aw_v, w_v, ar_v} <= '0;
    {tbs, b_r, r_r} <= 3'h7;
    {mode, gap, awa, ara, wd} <= '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset_n low", rst_n, 1'b0);
    check("reset high", rst, 1'b1);
    check("supply_low_n low", low_n, 1'b0);
    check("mem_sel forced", msel_o, 1'b1);
    rd({1'b0, REG_CTRL, 2'b00});
    check("ctrl reset", d[0], CTRL_WDEN_RST);
    rd(5'h10);
    check("unmapped resp", resp, RESP_SLVERR);
    check("unmapped data", d, 32'h0);
    wr({1'b0, REG_IRQ_MASK, 2'b00}, 32'h1);
    check("mask resp", resp, RESP_OKAY);
    // supply returns, strobe held steady
    {sup, fail} <= 2'h3;
    gap <= 8'h08;
    mode <= 2'h2;
    repeat (4) @(posedge clk);
    check("supply_low_n up", low_n, 1'b1);
    check("fail warning up", fw_n, 1'b1);
    check("mem_sel follows", msel_o, 1'b0);
    check("reset held", rst_n, 1'b0);
    wait_rst(1'b1);
    check("hold long enough", 32'(n + 4 >= HT * TK), 1);
    check("hold bounded", 32'(n <= (HT + 2) * TK + 4), 1);
    check("reset low", rst, 1'b0);
    wait_exp(1'b0);
    check("long timeout", 32'(n >= (WL - 1) * TK && n <= (WL + 2) * TK), 1);
    repeat (2) @(posedge clk);
    check("expiry reset", rst_n, 1'b0);
    check("irq raised", irq, 1'b1);
    rd({1'b0, REG_IRQ_STAT, 2'b00});
    check("expiry event", d[0], 1'b1);
    wr({1'b0, REG_IRQ_STAT, 2'b00}, 32'h1);
    @(posedge clk);
    check("irq cleared", irq, 1'b0);
    wait_rst(1'b1);
    wait_rst(1'b0);
    check("repeat pulse", 32'(n >= (WL - 1) * TK && n <= (WL + 3) * TK), 1);
    // host services the strobe
    mode <= 2'h1;
    wait_exp(1'b1);
    check("expiry cleared", 32'(n <= 16), 1);
    wait_rst(1'b1);
    count_trips(300);
    check("serviced quiet", n, 0);
    mode <= 2'h2;
    wait_exp(1'b0);
    check("short timeout", 32'(n >= (WS - 3) * TK && n <= (WS + 2) * TK), 1);
    // float the strobe after recovery
    mode <= 2'h1;
    wait_rst(1'b1);
    mode <= 2'h0;
    count_trips(200);
    check("floating quiet", n, 0);
    // backup mode
    swo <= 1'b1;
    repeat (4) @(posedge clk);
    check("backup outputs", {rst_n, rst, fw_n, low_n, exp_n, msel_o, bk}, 7'h27);
    {fail, msel, tbi, tbs} <= 4'h2;
    mode <= 2'h1;
    repeat (30) @(posedge clk);
    check("backup ignores", {rst_n, rst, fw_n, low_n, exp_n, msel_o, bk}, 7'h27);
    rd({1'b0, REG_STATUS, 2'b00});
    check("status bits", d[1:0], 2'h3);
    swo <= 1'b0;
    repeat (4) @(posedge clk);
    check("backup left", bk, 1'b0);
    finish_test();
  end

  // hang guard, far above the expected run
  initial begin
    #50000;
    fails++;
    finish_test();
  end
endmodule
